//--- sim/test_register_move_instr_decode.sv
// Self-checking testbench for the register-move execution core.
`timescale 1ns/1ps
module test_register_move_instr_decode
  import rmd_pkg::*;
;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  logic                ref_clk     = 1'b0;
  logic                rst         = 1'b1;
  logic [INSTR_W-1:0]  instr       = 14'h0000;
  logic [DATA_W-1:0]   fileRdData  = 8'h00;
  logic                instrTake;
  rmd_file_req_t       fileReq;
  logic [DATA_W-1:0]   acc;
  logic                zeroFlag;
  rmd_phase_t          phase;
  logic [DATA_W-1:0]   expAcc      = 8'h00;
  logic                expZero     = 1'b0;
  int                  errors      = 0;
  int                  comparisons = 0;

  // The core under test.
  rmd_core dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .instr      (instr),
    .instrTake  (instrTake),
    .fileRdData (fileRdData),
    .fileReq    (fileReq),
    .acc        (acc),
    .zeroFlag   (zeroFlag),
    .phase      (phase)
  );

  // The clock toggles every 2.5 ns, half of its 5 ns period.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares one byte-wide result and counts it.
  task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : compare

  // Runs one instruction over its four quarters, entered on a Q1 falling edge.
  task automatic exec(input logic [13:0] w, input logic [7:0] rd, input logic wr,
                      input logic [7:0] wd);
    instr = w;
    fileRdData = rd;
    compare({7'h00, instrTake}, 8'h01, "take");
    for (int i = 1; i <= 4; i++) begin
      @(negedge ref_clk);
      compare({6'h00, phase}, {6'h00, 2'(i % 4)}, "phase");
      compare({7'h00, instrTake}, {7'h00, i == 4}, "take");
      if (i == 1) compare({1'b0, fileReq.addr}, {1'b0, w[6:0]}, "addr");
      compare({7'h00, fileReq.wrEn}, {7'h00, wr && i == 3}, "wrEn");
      if (wr && i == 3) compare(fileReq.wrData, wd, "wrData");
    end
    compare(acc, expAcc, "acc");
    compare({7'h00, zeroFlag}, {7'h00, expZero}, "zero");
  endtask : exec

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Copy into the accumulator, zero byte first, at both address ends.
  task automatic test_copy_to_acc;
    expZero = 1'b1;
    exec({6'h08, 1'b0, 7'h7f}, 8'h00, 1'b0, 8'h00);
    expAcc = 8'ha5;
    expZero = 1'b0;
    exec({6'h08, 1'b0, 7'h00}, 8'ha5, 1'b0, 8'h00);
    $display("test_copy_to_acc done");
  endtask : test_copy_to_acc

  // Copy onto itself leaves the accumulator alone but moves the flag.
  task automatic test_copy_to_file;
    exec({6'h08, 1'b1, 7'h2a}, 8'h3c, 1'b1, 8'h3c);
    expZero = 1'b1;
    exec({6'h08, 1'b1, 7'h01}, 8'h00, 1'b1, 8'h00);
    $display("test_copy_to_file done");
  endtask : test_copy_to_file

  // Store writes the accumulator and keeps the flag, whichever its value.
  task automatic test_store;
    exec({7'h01, 7'h55}, 8'h00, 1'b1, 8'ha5);
    expAcc = 8'h5a;
    expZero = 1'b0;
    exec({6'h08, 1'b0, 7'h10}, 8'h5a, 1'b0, 8'h00);
    exec({7'h01, 7'h7f}, 8'h00, 1'b1, 8'h5a);
    $display("test_store done");
  endtask : test_store

  // Near-miss words must neither write nor touch the state.
  task automatic test_refused;
    exec(14'h0055, 8'h00, 1'b0, 8'h00);
    exec(14'h0955, 8'h00, 1'b0, 8'h00);
    exec(14'h28d5, 8'h00, 1'b0, 8'h00);
    $display("test_refused done");
  endtask : test_refused

  // A reset in mid-store drops the write and clears the core state.
  task automatic test_mid_reset;
    instr = {7'h01, 7'h33};
    repeat (2) @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    compare({6'h00, phase}, 8'h00, "rst phase");
    compare({7'h00, fileReq.wrEn}, 8'h00, "rst wrEn");
    compare(acc, 8'h00, "rst acc");
    compare({7'h00, zeroFlag}, 8'h00, "rst zero");
    expAcc = 8'h00;
    expZero = 1'b0;
    exec({6'h08, 1'b1, 7'h12}, 8'h80, 1'b1, 8'h80);
    $display("test_mid_reset done");
  endtask : test_mid_reset

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  // Reset for six cycles, then back-to-back instructions from the first Q1.
  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    test_copy_to_acc();
    test_copy_to_file();
    test_store();
    test_refused();
    test_mid_reset();
    end_of_test();
  end

  // Cuts a hang short well after the expected 54 or so cycles.
  initial begin
    repeat (400) @(posedge ref_clk);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule : test_register_move_instr_decode

//--- src/rmd_core.sv
// Quarter-phase execution of the register copy and accumulator store.
`timescale 1ns/1ps
module rmd_core
  import rmd_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Instruction fetch path
  input  wire logic [INSTR_W-1:0] instr,
  output logic                    instrTake,
  // File register port
  input  wire logic [DATA_W-1:0]  fileRdData,
  output rmd_file_req_t           fileReq,
  // Core state
  output logic [DATA_W-1:0]       acc,
  output logic                    zeroFlag,
  output rmd_phase_t              phase
);

  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  rmd_phase_t        phase_q;
  rmd_dec_t          decOut;
  rmd_dec_t          dec_q;
  logic [DATA_W-1:0] src_q;
  logic [DATA_W-1:0] res_q;
  logic [DATA_W-1:0] acc_q;
  logic              zero_q;
  rmd_file_req_t     req_q;

  // Decoder instance.
  rmd_decode uDec (
    .instr (instr),
    .dec   (decOut)
  );

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  // Steps Q1 to Q4 each clock, one instruction per four steps.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= rmd_phase_t'(phase_q + 2'd1);
    end
  end

  // The fetched word is consumed in Q1.
  assign instrTake = (phase_q == PH_Q1);

  // ----------------------------------------
  // Decode in Q1
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dec_q <= '0;
    end else if (phase_q == PH_Q1) begin
      dec_q <= decOut;
    end
  end

  // ----------------------------------------
  // Read source in Q2, process in Q3
  // ----------------------------------------
  // Copy reads the file register; store takes the accumulator.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_q <= '0;
      res_q <= '0;
    end else begin
      if (phase_q == PH_Q2) begin
        src_q <= (dec_q.op == OP_STORE) ? acc_q : fileRdData;
      end
      if (phase_q == PH_Q3) begin
        res_q <= src_q;
      end
    end
  end

  // ----------------------------------------
  // Write destination in Q4
  // ----------------------------------------
  // Accumulator is written only by a copy with d clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_q <= ACC_RESET;
    end else if (phase_q == PH_Q4 && dec_q.op == OP_COPY && !dec_q.toFile) begin
      acc_q <= res_q;
    end
  end

  // Zero flag follows a copy of either destination; store leaves it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else if (phase_q == PH_Q4 && dec_q.op == OP_COPY) begin
      zero_q <= (res_q == '0);
    end
  end

  // File write request, asserted during Q4 of a file destination.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_q <= '0;
    end else begin
      req_q.wrEn   <= 1'b0;
      req_q.addr   <= (phase_q == PH_Q1) ? decOut.addr : req_q.addr;
      req_q.wrData <= req_q.wrData;
      if (phase_q == PH_Q3) begin
        req_q.wrData <= src_q;
        if ((dec_q.op == OP_COPY && dec_q.toFile) || dec_q.op == OP_STORE) begin
          req_q.wrEn <= 1'b1;
        end
      end
    end
  end

  // Registered state drives the outputs directly.
  assign fileReq  = req_q;
  assign acc      = acc_q;
  assign zeroFlag = zero_q;
  assign phase    = phase_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Q1 sees the copy opcode, so the decoded kind must be copy.
  chk_copy_decode: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:8] == 6'h08 |=> dec_q.op == OP_COPY)
    else $error("copy opcode not decoded");

  // The seven-bit address is held for the rest of the cycle.
  chk_copy_addr: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:8] == 6'h08 |=> req_q.addr == $past(instr[6:0]))
    else $error("copy address not held");

  // A copy to the accumulator writes no file and loads the Q2 byte.
  chk_copy_to_acc: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:7] == 7'h10
      |-> ##3 !req_q.wrEn ##1 acc_q == $past(fileRdData, 3))
    else $error("copy to accumulator wrong");

  // Only a copy with d clear may change the accumulator, at the end of Q4.
  chk_acc_only_copy: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(acc_q) |-> $past(phase_q) == PH_Q4 && $past(dec_q.op) == OP_COPY
      && !$past(dec_q.toFile))
    else $error("accumulator changed outside a copy");

  // A copy onto itself writes the Q2 byte back and spares the accumulator.
  chk_copy_to_file: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:7] == 7'h11
      |-> ##3 req_q.wrEn && req_q.wrData == $past(fileRdData, 2)
        && req_q.addr == $past(instr[6:0], 3) ##1 $stable(acc_q))
    else $error("copy to file wrong");

  // The flag follows the moved byte after every copy.
  chk_zero_copy: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q4 && dec_q.op == OP_COPY |=> zero_q == (res_q == 8'h00))
    else $error("zero flag not updated");

  // The flag is worked out from the byte on the read port in Q2.
  chk_zero_from_input: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:8] == 6'h08
      |-> ##4 zero_q == ($past(fileRdData, 3) == 8'h00))
    else $error("zero flag not taken from the moved byte");

  // Q1 sees the store pattern, so the decoded kind must be store.
  chk_store_decode: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:7] == 7'h01 |=> dec_q.op == OP_STORE)
    else $error("store opcode not decoded");

  // A store leaves the flag and the accumulator as they were.
  chk_store_flags: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q4 && dec_q.op == OP_STORE |=> $stable(zero_q) && $stable(acc_q))
    else $error("store changed state");

  // A store writes the accumulator to the addressed register in Q4.
  chk_store_write: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:7] == 7'h01
      |-> ##3 req_q.wrEn && req_q.addr == $past(instr[6:0], 3)
        && req_q.wrData == acc_q)
    else $error("store did not write accumulator");

  // Any other word neither writes nor touches the core state.
  chk_refused_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 && instr[13:8] != 6'h08 && instr[13:7] != 7'h01
      |-> ##3 !req_q.wrEn ##1 $stable(acc_q) && $stable(zero_q))
    else $error("unknown word changed state");

  // The quarters run in order and wrap after Q4.
  chk_phase_order: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q1 |-> ##3 phase_q == PH_Q4 ##1 phase_q == PH_Q1)
    else $error("phase order broken");

  // A new word is taken right after every Q4.
  chk_take_after_q4: assert property (@(posedge ref_clk) disable iff (rst)
    phase_q == PH_Q4 |=> instrTake)
    else $error("word not taken after Q4");

  // The file is written only in Q4.
  chk_wr_in_q4: assert property (@(posedge ref_clk) disable iff (rst)
    req_q.wrEn |-> phase_q == PH_Q4)
    else $error("write outside Q4");

  // A write strobe lasts a single quarter.
  chk_one_write: assert property (@(posedge ref_clk) disable iff (rst)
    req_q.wrEn |=> !req_q.wrEn)
    else $error("write strobe longer than one quarter");

  // Any change of the flag comes from a copy and matches its byte.
  chk_zero_value: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(zero_q) |-> $past(dec_q.op) == OP_COPY && zero_q == ($past(res_q) == 8'h00))
    else $error("zero flag value wrong");

endmodule : rmd_core

//--- src/rmd_decode.sv
// Combinational decoder of the two data-move instruction words.
`timescale 1ns/1ps
module rmd_decode
  import rmd_pkg::*;
(
  // Instruction word in
  input  wire logic [INSTR_W-1:0] instr,
  // Decoded fields out
  output rmd_dec_t                dec
);

  // ----------------------------------------
  // Opcode match
  // ----------------------------------------
  // Compares the upper fields and splits out destination and address.
  always_comb begin
    dec.op     = OP_NONE;
    dec.toFile = instr[DEST_BIT];
    dec.addr   = instr[ADDR_W-1:0];
    if (instr[13:8] == OP_COPY_HI) begin
      dec.op = OP_COPY;
    end else if (instr[13:7] == OP_STORE_HI) begin
      dec.op = OP_STORE;
    end
  end

endmodule : rmd_decode

//--- src/rmd_pkg.sv
// Package of constants and carrier types for the register-move decoder.
package rmd_pkg;

  // ----------------------------------------
  // Instruction word layout
  // ----------------------------------------
  localparam int          INSTR_W       = 14;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam logic [5:0]  OP_COPY_HI    = 6'h08;
  localparam logic [6:0]  OP_STORE_HI   = 7'h01;
  localparam int          DEST_BIT      = 7;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

  // ----------------------------------------
  // Quarter phases of one instruction cycle
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } rmd_phase_t;

  // Decoded kind of the current instruction.
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_COPY  = 2'b01,
    OP_STORE = 2'b10
  } rmd_op_t;

  // File register port carrier.
  typedef struct packed {
    logic              wrEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } rmd_file_req_t;

  // Result of decoding one instruction word.
  typedef struct packed {
    rmd_op_t           op;
    logic              toFile;
    logic [ADDR_W-1:0] addr;
  } rmd_dec_t;

endpackage : rmd_pkg
